// file: src/asp_defines.svh
`ifndef ASP_DEFINES_SVH
`define ASP_DEFINES_SVH

// Register addresses carried in the low six bits of the communications byte.
`define ASP_ADDR_COMM 6'h00
`define ASP_ADDR_PORT 6'h01
`define ASP_ADDR_REV 6'h02
`define ASP_ADDR_STATUS 6'h04
`define ASP_CHDATA_GROUP 4'h2
`define ASP_CONVTIME_GROUP 4'hc

// Communications byte fields.
`define ASP_COMM_ZERO_BIT 7
`define ASP_COMM_RW_BIT 6

// Port register fields.
`define ASP_PORT_P0_BIT 7
`define ASP_PORT_P1_BIT 6
`define ASP_PORT_P0DIR_BIT 5
`define ASP_PORT_P1DIR_BIT 4
`define ASP_PORT_RFS_BIT 3
`define ASP_PORT_SYNC_BIT 0
`define ASP_PORT_WMASK 8'hf9

// Reset values.
`define ASP_PORT_RESET 8'h30
`define ASP_CONVTIME_RESET 8'h11
`define ASP_REG_RESET 8'h00

// Serial framing.
`define ASP_FRAME_LAST 3'h7

`endif

// file: src/asp_pkg.sv
package asp_pkg;

    typedef logic [5:0] asp_addr_t;
    typedef logic [7:0] asp_byte_t;

    typedef enum logic [1:0] {
        st_expect_comm,
        st_write_data,
        st_read_data
    } asp_state_t;

endpackage : asp_pkg

// file: src/asp_link_shifter.sv
`timescale 1ns/1ns
`include "asp_defines.svh"

module asp_link_shifter
    import asp_pkg::*;
(
    // Link clock and frame control
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic link_hold,
    // Serial data pins
    input wire logic din,
    output logic dout,
    output logic dout_oe,
    // Byte exchange with the reference domain
    output asp_byte_t rx_byte,
    output logic rx_toggle,
    input wire asp_byte_t tx_byte
);

    logic frame_arst_n;
    logic [2:0] bit_cnt;
    logic [6:0] shift_in;
    asp_byte_t shift_out;

    // A deselected part holds its bit counter in reset, so every selection starts on a
    // byte boundary; a tied-low select relies on the reset hold for alignment instead.
    assign frame_arst_n = ~(cs_n | link_hold);

    //////////////////////////////////////////////////////////////////////////////////
    // active-low select
    assign dout_oe = ~cs_n;

    always_ff @(posedge sclk or negedge frame_arst_n) begin
        if (!frame_arst_n) begin
            bit_cnt <= 3'h0;
            shift_in <= 7'h00;
        end else begin
            bit_cnt <= bit_cnt + 3'h1;
            shift_in <= {shift_in[5:0], din};
        end
    end

    // input shift register
    // The toggle is cleared only by the reset hold, never by the select, so a
    // deselect cannot fake a byte event on the far side.
    always_ff @(posedge sclk or posedge link_hold) begin
        if (link_hold) begin
            rx_byte <= `ASP_REG_RESET;
            rx_toggle <= 1'b0;
        end else if (!cs_n && bit_cnt == `ASP_FRAME_LAST) begin
            rx_byte <= {shift_in, din};
            rx_toggle <= ~rx_toggle;
        end
    end

    //////////////////////////////////////////////////////////////////////////////////
    // output shift register
    // The first falling edge of a byte loads the word; tx_byte must already be
    // settled then, which the host guarantees by its gap after a read command.
    always_ff @(negedge sclk or negedge frame_arst_n) begin
        if (!frame_arst_n) begin
            shift_out <= `ASP_REG_RESET;
        end else if (bit_cnt == 3'h0) begin
            shift_out <= tx_byte;
        end else begin
            shift_out <= {shift_out[6:0], 1'b0};
        end
    end

    assign dout = shift_out[7];

endmodule : asp_link_shifter

// file: src/asp_pin_ctrl.sv
`timescale 1ns/1ns
`include "asp_defines.svh"


module asp_pin_ctrl
    import asp_pkg::*;
#(
    // Revision readback; the value is arbitrary.
    parameter asp_byte_t REVISION_CODE = 8'h00
)
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Serial port pins
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic din,
    output logic dout,
    output logic dout_oe,
    // General-purpose pin zero
    input wire logic gp_pin_zero_in,
    output logic gp_pin_zero_out,
    output logic gp_pin_zero_oe,
    // General-purpose pin one, also the sync input
    input wire logic sync_or_gp_pin_one_in,
    output logic sync_or_gp_pin_one_out,
    output logic sync_or_gp_pin_one_oe,
    // Converter core status
    input wire logic conv_mode,
    input wire logic cal_mode,
    input wire logic cal_start,
    input wire logic cal_done,
    input wire logic [3:0] chan_data_new,
    input wire logic [3:0] chan_enabled,
    input wire asp_byte_t chan_data_value,
    // Ready and core control
    output logic rdy_n,
    output logic core_rst_n,
    output logic osc_run,
    output logic filter_sync_n,
    // Register write report to the core
    output logic wr_pulse,
    output asp_addr_t wr_addr,
    output asp_byte_t wr_data,
    output logic [1:0] access_channel
);

    //////////////////////////////////////////////////////////////////////////////////
    // Decoding helpers.

    function automatic logic is_chan_data(input asp_addr_t addr);
        is_chan_data = (addr[5:2] == `ASP_CHDATA_GROUP);
    endfunction : is_chan_data

    function automatic logic [1:0] chan_of(input asp_addr_t addr);
        chan_of = addr[1:0];
    endfunction : chan_of

    function automatic logic is_read_only(input asp_addr_t addr);
        is_read_only = is_chan_data(addr) || addr == `ASP_ADDR_REV
            || addr == `ASP_ADDR_STATUS || addr == `ASP_ADDR_COMM;
    endfunction : is_read_only

    //////////////////////////////////////////////////////////////////////////////////
    // Declarations.

    logic link_hold;
    asp_byte_t link_rx_byte;
    logic link_rx_toggle;
    asp_byte_t tx_hold;
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic toggle_seen;
    logic rx_evt;
    logic gp0_level;
    logic gp1_level;
    asp_state_t state;
    asp_addr_t cur_addr;
    asp_byte_t port_reg;
    asp_byte_t regs [0:63];
    asp_byte_t rd_value;
    logic [3:0] unread;
    logic [3:0] unread_clr;
    logic cal_flag;
    logic conv_ready;
    asp_addr_t cmd_addr;

    //////////////////////////////////////////////////////////////////////////////////
    // Reset distribution.

    assign osc_run = 1'b1;

    always_ff @(posedge ref_clk) begin
        core_rst_n <= rst_n;
    end

    // The link logic has no free-running clock of its own, so it is held in
    // asynchronous reset by this registered level while the part is in reset.
    always_ff @(posedge ref_clk) begin
        link_hold <= ~rst_n;
    end

    //////////////////////////////////////////////////////////////////////////////////
    // Serial link end.

    asp_link_shifter u_link (
        .sclk(sclk),
        .cs_n(cs_n),
        .link_hold(link_hold),
        .din(din),
        .dout(dout),
        .dout_oe(dout_oe),
        .rx_byte(link_rx_byte),
        .rx_toggle(link_rx_toggle),
        .tx_byte(tx_hold)
    );

    //////////////////////////////////////////////////////////////////////////////////
    // Input synchronisers: byte toggle and both general-purpose pins.

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sync1 <= 3'h0;
            sync2 <= 3'h0;
            toggle_seen <= 1'b0;
        end else begin
            sync1 <= {sync_or_gp_pin_one_in, gp_pin_zero_in, link_rx_toggle};
            sync2 <= sync1;
            toggle_seen <= sync2[0];
        end
    end

    // The received byte is stable from its toggle until the next byte ends,
    // far longer than the two-stage delay, so it is read directly.
    // selected traffic only
    assign rx_evt = sync2[0] ^ toggle_seen;
    assign cmd_addr = link_rx_byte[5:0];

    //////////////////////////////////////////////////////////////////////////////////
    // Transfer sequencing.

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state <= st_expect_comm;
            cur_addr <= `ASP_ADDR_COMM;
        end else if (rx_evt) begin
            unique case (state)
                st_expect_comm: begin
                    if (!link_rx_byte[`ASP_COMM_ZERO_BIT]) begin
                        cur_addr <= cmd_addr;
                        state <= link_rx_byte[`ASP_COMM_RW_BIT] ? st_read_data : st_write_data;
                    end
                end
                st_write_data: begin
                    state <= st_expect_comm;
                end
                st_read_data: begin
                    state <= st_expect_comm;
                end
            endcase
        end
    end

    always_comb begin
        rd_value = regs[cmd_addr];
        if (cmd_addr == `ASP_ADDR_PORT) begin
            rd_value = {gp0_level, gp1_level, port_reg[5:0]};
        end else if (cmd_addr == `ASP_ADDR_STATUS) begin
            rd_value = {4'h0, unread};
        end else if (cmd_addr == `ASP_ADDR_REV) begin
            rd_value = REVISION_CODE;
        end else if (cmd_addr == `ASP_ADDR_COMM) begin
            rd_value = `ASP_REG_RESET;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            tx_hold <= `ASP_REG_RESET;
        end else if (rx_evt && state == st_expect_comm && !link_rx_byte[`ASP_COMM_ZERO_BIT]
                     && link_rx_byte[`ASP_COMM_RW_BIT]) begin
            tx_hold <= rd_value;
        end
    end

    //////////////////////////////////////////////////////////////////////////////////
    // Register storage.

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            for (int i = 0; i < 64; i++) begin
                regs[i] <= (i[5:2] == `ASP_CONVTIME_GROUP) ? `ASP_CONVTIME_RESET
                                                           : `ASP_REG_RESET;
            end
        end else begin
            if (rx_evt && state == st_write_data && !is_read_only(cur_addr)) begin
                regs[cur_addr] <= link_rx_byte;
            end
            for (int i = 0; i < 4; i++) begin
                if (chan_data_new[i]) begin
                    regs[{`ASP_CHDATA_GROUP, i[1:0]}] <= chan_data_value;
                end
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            wr_pulse <= 1'b0;
            wr_addr <= `ASP_ADDR_COMM;
            wr_data <= `ASP_REG_RESET;
            access_channel <= 2'h0;
        end else begin
            wr_pulse <= rx_evt && state == st_write_data;
            if (rx_evt && state == st_write_data) begin
                wr_addr <= cur_addr;
                wr_data <= link_rx_byte;
                access_channel <= chan_of(cur_addr);
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////////////
    // Port register and general-purpose pins.

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            port_reg <= `ASP_PORT_RESET;
        end else if (rx_evt && state == st_write_data && cur_addr == `ASP_ADDR_PORT) begin
            port_reg <= link_rx_byte & `ASP_PORT_WMASK;
        end
    end

    assign gp0_level = port_reg[`ASP_PORT_P0DIR_BIT] ? sync2[1] : port_reg[`ASP_PORT_P0_BIT];
    assign gp1_level = port_reg[`ASP_PORT_P1DIR_BIT] ? sync2[2] : port_reg[`ASP_PORT_P1_BIT];

    // A direction bit of one makes the pin an input, which is also its reset state,
    // so an unconfigured pin never fights the board; such a pin must be tied off.
    // inputs tied off
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            gp_pin_zero_oe <= 1'b0;
            gp_pin_zero_out <= 1'b0;
        end else begin
            gp_pin_zero_oe <= ~port_reg[`ASP_PORT_P0DIR_BIT];
            gp_pin_zero_out <= port_reg[`ASP_PORT_P0_BIT];
        end
    end

    // pin one direction
    // Sync use forces the pin to an input so it can never drive its own sync line.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sync_or_gp_pin_one_oe <= 1'b0;
            sync_or_gp_pin_one_out <= 1'b0;
        end else begin
            sync_or_gp_pin_one_oe <= ~port_reg[`ASP_PORT_P1DIR_BIT]
                                     & ~port_reg[`ASP_PORT_SYNC_BIT];
            sync_or_gp_pin_one_out <= port_reg[`ASP_PORT_P1_BIT];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            filter_sync_n <= 1'b1;
        end else begin
            filter_sync_n <= port_reg[`ASP_PORT_SYNC_BIT] ? sync2[2] : 1'b1;
        end
    end

    //////////////////////////////////////////////////////////////////////////////////
    // Ready output.

    generate
        for (genvar ch = 0; ch < 4; ch++) begin : g_unread
            assign unread_clr[ch] = rx_evt && state == st_read_data
                && is_chan_data(cur_addr) && chan_of(cur_addr) == ch;
            // New data wins over a read that clears in the same cycle.
            always_ff @(posedge ref_clk) begin
                if (!rst_n) begin
                    unread[ch] <= 1'b0;
                end else if (chan_data_new[ch]) begin
                    unread[ch] <= 1'b1;
                end else if (unread_clr[ch]) begin
                    unread[ch] <= 1'b0;
                end
            end
        end
    endgenerate

    assign conv_ready = port_reg[`ASP_PORT_RFS_BIT]
        ? (chan_enabled != 4'h0 && (unread & chan_enabled) == chan_enabled)
        : (unread != 4'h0);

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cal_flag <= 1'b0;
        end else if (cal_done) begin
            cal_flag <= 1'b1;
        end else if (cal_start) begin
            cal_flag <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rdy_n <= 1'b1;
        end else if (cal_mode) begin
            rdy_n <= ~cal_flag;
        end else if (conv_mode) begin
            rdy_n <= ~conv_ready;
        end else begin
            rdy_n <= 1'b1;
        end
    end

    //////////////////////////////////////////////////////////////////////////////////
    // Checks.

    a_reset_state: assert property (
        @(posedge ref_clk) !rst_n |=> (state == st_expect_comm && port_reg == `ASP_PORT_RESET
            && !core_rst_n && rdy_n))
        else $error("reset did not restore power-on state");

    a_osc_running: assert property (
        @(posedge ref_clk) (!rst_n ##1 !rst_n) |-> osc_run && !core_rst_n && link_hold)
        else $error("oscillator stopped or core not held in reset");

    a_gp0_drive: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        $past(rst_n) |-> (gp_pin_zero_oe == !$past(port_reg[5])
            && (!gp_pin_zero_oe || gp_pin_zero_out == $past(port_reg[7]))))
        else $error("pin zero drive does not follow port register");

    a_gp1_drive: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        $past(rst_n) |-> (sync_or_gp_pin_one_oe == !($past(port_reg[4]) || $past(port_reg[0]))
            && (!sync_or_gp_pin_one_oe || sync_or_gp_pin_one_out == $past(port_reg[6]))))
        else $error("pin one direction does not follow port register");

    a_sync_follow: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        ($past(rst_n, 3) && $past(port_reg[0])) |-> filter_sync_n == $past(sync_or_gp_pin_one_in, 3))
        else $error("sync output does not follow pin one");

    a_rdy_any: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (conv_mode && !cal_mode && !port_reg[3] && unread != 4'h0) |=> !rdy_n)
        else $error("ready not low with unread data");

    a_rdy_cal: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (cal_mode && cal_done) ##1 cal_mode |=> !rdy_n)
        else $error("ready not low after calibration done");

    a_read_load: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (rx_evt && state == st_expect_comm && link_rx_byte[7:6] == 2'h1)
            |=> (state == st_read_data && tx_hold == $past(rd_value)))
        else $error("read word not loaded for output");

    a_write_store: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (rx_evt && state == st_write_data) |=> (wr_pulse && wr_data == $past(link_rx_byte)
            && wr_addr == $past(cur_addr) && state == st_expect_comm))
        else $error("written byte not transferred");

    a_chan_decode: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        wr_pulse |-> access_channel == wr_addr[1:0])
        else $error("channel number not taken from low address bits");

    a_comm_first: assert property (
        @(posedge ref_clk) $rose(rst_n) |-> (state == st_expect_comm && !wr_pulse))
        else $error("interface not waiting for a communications byte");

endmodule : asp_pin_ctrl

// file: tb/asp_host_model.sv
`timescale 1ns/1ns

module asp_host_model
    import asp_pkg::*;
(
    // Serial port pins
    output logic sclk,
    output logic cs_n,
    output logic din,
    input wire logic dout
);
    logic hold_low;

    initial begin
        sclk = 1'b1;
        cs_n = 1'b1;
        din = 1'b1;
        hold_low = 1'b0;
    end

    task automatic select_tied();
        hold_low = 1'b1;
        cs_n = 1'b0;
    endtask : select_tied

    task automatic xfer(input asp_byte_t tx, output asp_byte_t rx);
        for (int i = 7; i >= 0; i--) begin
            sclk = 1'b0;
            din = tx[i];
            #62;
            sclk = 1'b1;
            rx[i] = dout;
            #63;
        end
        // The line must not keep showing the last bit once it is no longer sampled.
        #1;
        din = ~din;
    endtask : xfer

    task automatic frame(input logic sel, input asp_byte_t tx);
        asp_byte_t rx;
        cs_n = ~sel;
        #100;
        xfer(tx, rx);
        #100;
        cs_n = 1'b1;
        #100;
    endtask : frame

    task automatic access(input logic rd, input asp_addr_t a, input asp_byte_t wd,
                          output asp_byte_t rdat);
        asp_byte_t rx;
        cs_n = 1'b0;
        #100;
        xfer({1'b0, rd, a}, rx);
        if (rd) begin
            #450;
        end
        xfer(wd, rdat);
        #100;
        cs_n = ~hold_low;
        #100;
    endtask : access
endmodule : asp_host_model

// file: tb/asp_pin_ctrl_tb.sv
`timescale 1ns/1ns

module asp_pin_ctrl_tb
    import asp_pkg::*;
;
    logic ref_clk, rst_n, sclk, cs_n, din, dout, dout_oe;
    logic p0_in, p0_out, p0_oe, p1_in, p1_out, p1_oe;
    logic conv_mode, cal_mode, cal_start, cal_done;
    logic [3:0] chan_data_new, chan_enabled;
    asp_byte_t chan_data_value, wr_data, d;
    logic rdy_n, core_rst_n, osc_run, filter_sync_n, wr_pulse;
    asp_addr_t wr_addr;
    logic [1:0] access_channel;
    int miscompares = 0;
    int comparisons = 0;

    asp_pin_ctrl u_asp_pin_ctrl (.ref_clk(ref_clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n),
        .din(din), .dout(dout), .dout_oe(dout_oe), .gp_pin_zero_in(p0_in),
        .gp_pin_zero_out(p0_out), .gp_pin_zero_oe(p0_oe), .sync_or_gp_pin_one_in(p1_in),
        .sync_or_gp_pin_one_out(p1_out), .sync_or_gp_pin_one_oe(p1_oe),
        .conv_mode(conv_mode), .cal_mode(cal_mode), .cal_start(cal_start),
        .cal_done(cal_done), .chan_data_new(chan_data_new), .chan_enabled(chan_enabled),
        .chan_data_value(chan_data_value), .rdy_n(rdy_n), .core_rst_n(core_rst_n),
        .osc_run(osc_run), .filter_sync_n(filter_sync_n), .wr_pulse(wr_pulse),
        .wr_addr(wr_addr), .wr_data(wr_data), .access_channel(access_channel));
    asp_host_model u_asp_host_model (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        if (miscompares == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : final_report

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : cyc

    task automatic wait_wr();
        int n;
        for (n = 0; n < 150 && wr_pulse !== 1'b1; n++) @(posedge ref_clk);
        if (n == 150) begin
            miscompares++;
            $display("MISMATCH %0t no write report", $time);
            final_report();
        end
    endtask : wait_wr

    task automatic wr(input asp_addr_t a, input asp_byte_t v);
        asp_byte_t x;
        fork
            u_asp_host_model.access(1'b0, a, v, x);
            wait_wr();
        join
        chk({2'b00, wr_addr}, {2'b00, a});
        chk(wr_data, v);
        chk({6'h00, access_channel}, {6'h00, a[1:0]});
        @(posedge ref_clk);
    endtask : wr

    task automatic rd(input asp_addr_t a, output asp_byte_t v);
        u_asp_host_model.access(1'b1, a, 8'h00, v);
        @(posedge ref_clk);
    endtask : rd

    task automatic new_data(input int ch, input asp_byte_t v);
        @(posedge ref_clk);
        chan_data_new <= 4'h1 << ch;
        chan_data_value <= v;
        @(posedge ref_clk);
        chan_data_new <= 4'h0;
    endtask : new_data

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_n = 1'b0;
        {p0_in, p1_in, conv_mode, cal_mode, cal_start, cal_done} = 6'b10_0000;
        chan_data_new = 4'h0;
        chan_enabled = 4'h3;
        chan_data_value = 8'h00;
        cyc(2);
        chk({4'h0, rdy_n, core_rst_n, osc_run, filter_sync_n}, 8'h0b);
        chk({3'h0, dout, dout_oe, p0_oe, p1_oe, wr_pulse}, 8'h00);
        cyc(1);
        rst_n <= 1'b1;
        cyc(4);
        chk({7'h00, core_rst_n}, 8'h01);
        rd(6'h01, d);
        chk(d, 8'hb0);
        wr(6'h01, 8'hc8);
        cyc(2);
        chk({4'h0, p0_oe, p0_out, p1_oe, p1_out}, 8'h0f);
        rd(6'h01, d);
        chk(d, 8'hc8);
        wr(6'h29, 8'h5a);
        u_asp_host_model.frame(1'b1, 8'hc1);
        rd(6'h29, d);
        chk(d, 8'h5a);
        u_asp_host_model.frame(1'b0, 8'h01);
        u_asp_host_model.frame(1'b0, 8'h00);
        rd(6'h01, d);
        chk(d, 8'hc8);
        conv_mode <= 1'b1;
        new_data(0, 8'h11);
        cyc(5);
        chk({7'h00, rdy_n}, 8'h01);
        new_data(1, 8'ha5);
        cyc(5);
        chk({7'h00, rdy_n}, 8'h00);
        rd(6'h09, d);
        chk(d, 8'ha5);
        cyc(5);
        chk({7'h00, rdy_n}, 8'h01);
        rd(6'h04, d);
        chk(d, 8'h01);
        wr(6'h01, 8'h01);
        cyc(5);
        chk({7'h00, rdy_n}, 8'h00);
        chk({6'h00, p0_oe, p1_oe}, 8'h02);
        p1_in <= 1'b0;
        cyc(6);
        chk({7'h00, filter_sync_n}, 8'h00);
        p1_in <= 1'b1;
        cyc(6);
        chk({7'h00, filter_sync_n}, 8'h01);
        cal_mode <= 1'b1;
        cal_start <= 1'b1;
        cyc(1);
        cal_start <= 1'b0;
        cyc(5);
        chk({7'h00, rdy_n}, 8'h01);
        cal_done <= 1'b1;
        cyc(1);
        cal_done <= 1'b0;
        cyc(4);
        chk({7'h00, rdy_n}, 8'h00);
        // A finish and a new start in one cycle: the finish wins.
        cal_done <= 1'b1;
        cal_start <= 1'b1;
        cyc(1);
        {cal_done, cal_start} <= 2'b00;
        cyc(4);
        chk({7'h00, rdy_n}, 8'h00);
        cal_start <= 1'b1;
        cyc(1);
        cal_start <= 1'b0;
        cyc(4);
        chk({7'h00, rdy_n}, 8'h01);
        rst_n <= 1'b0;
        cyc(3);
        chk({5'h00, osc_run, core_rst_n, rdy_n}, 8'h05);
        // From here on the select stays low: the reset hold aligns the bytes.
        u_asp_host_model.select_tied();
        rst_n <= 1'b1;
        cyc(4);
        chk({7'h00, dout_oe}, 8'h01);
        rd(6'h01, d);
        chk(d, 8'hf0);
        rd(6'h29, d);
        chk(d, 8'h00);
        final_report();
    end
endmodule : asp_pin_ctrl_tb
